// [logic/mbc_consts.vh]
// Constants for the bit and carry move execution block
`ifndef MBC_CONSTS_VH
`define MBC_CONSTS_VH
// APB byte addresses
`define MBC_ADDR_INSTR  12'h000
`define MBC_ADDR_FLAGS  12'h004
`define MBC_ADDR_WSEL   12'h008
`define MBC_ADDR_STAT   12'h00c
`define MBC_ADDR_DP0    12'h010
`define MBC_ADDR_DP1    12'h014
`define MBC_ADDR_ACC    12'h040
`define MBC_ADDR_ACC_E  12'h07c
`define MBC_ADDR_MOD    12'h100
`define MBC_ADDR_MOD_E  12'h1fc
// Fixed opcodes
`define MBC_OP_CLR_C    16'hda0a
`define MBC_OP_SET_C    16'hda1a
// Opcode nibbles
`define MBC_NIB_ACCOP   4'ha
`define MBC_NIB_BIT     4'h7
`define MBC_HI_ACC_FROM_C 4'hf
`define MBC_HI_C_FROM_ACC 4'he
// Operand specifier codes
`define MBC_SPEC_ACCN   4'h9
`define MBC_SPEC_ACC    7'h0a
`define MBC_SPEC_PFX    4'hb
`define MBC_SPEC_DP     4'hf
`define MBC_SPEC_DP_SEL 2'b11
`define MBC_SPEC_NUL    7'h76
`define MBC_SPEC_SYS    4'h8
`define MBC_SYS_WSEL    3'h0
`define MBC_SYS_FLAGS   3'h4
`define MBC_MOD_LAST    3'h5
`define MBC_SLOT_SYS    3'h6
// Prefix register that opens the upper accumulator bank
`define MBC_PFX_EXT     3'h2
// Flag bit positions
`define MBC_F_C         0
`define MBC_F_S         1
`define MBC_F_Z         2
`define MBC_F_E         3
`endif

// [logic/mbc_exec.v]
// Bit, carry and register transfer execution unit with APB register access
//
// Behaviour
// - Transfers copy 16 bits or the low byte, zero-fill a 16-bit destination from an 8-bit source.
// - A 16-bit destination fed from an 8-bit source takes a loaded prefix as its upper byte.
// - Prefix contents supply immediate upper bytes and reach the two-cycle destination space.
// - Opcode FA?A copies carry into the chosen working register bit and updates sign and zero.
// - Opcode EA?A loads carry from the chosen working register bit, nothing else changes.
// - Opcodes with second nibble 0111 load carry from a bit of an addressed source register.
// - Register bit to carry and bit clear accept only system module 8 and modules 0 to 5.
// - Opcode DA0A clears carry and nothing else.
// - Opcode DA1A sets carry and nothing else.
// - Bit clear writes zero to the chosen destination bit, touching carry or equal via flags.
// - In the prefixed space an accumulator index selects accumulators 8 to 15.
//
// The APB interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "mbc_consts.vh"
module mbc_exec #(
  parameter ACC_NUM = 16,
  parameter MOD_WORDS = 64
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr
);

  // Architectural state
  reg [15:0] acc_reg [0:ACC_NUM-1];
  reg [15:0] mod_reg [0:MOD_WORDS-1];
  reg [7:0]  pfx_reg [0:7];
  reg [15:0] dp_reg  [0:1];
  reg [7:0]  working_select_reg;
  reg [7:0]  cpu_flag_reg;
  reg [15:0] instr_reg;
  reg        pfx_valid_reg;
  reg [2:0]  pfx_idx_reg;
  reg        bad_reg;

  // Execution decode results
  reg        c_we, c_val, sz_we, acc_we, mod_we, ap_we, psf_we, dp_we, pfx_we, bad;
  reg [3:0]  acc_idx;
  reg [5:0]  mod_idx;
  reg [15:0] acc_val, mod_val, dp_val, src16, full16, acc_cur;
  reg [7:0]  b8_val, pfx_val, up8;
  reg [15:0] bw16;
  reg        dp_idx, src8;
  reg [2:0]  pfx_idx;
  reg [31:0] rd_val;
  reg        rd_err;
  integer    i;

  wire [15:0] ins = pwdata[15:0];
  wire [6:0]  dst = ins[14:8];
  wire [7:0]  spc = ins[7:0];
  wire        wr_acc = psel && penable && pready && pwrite;
  wire        exec = wr_acc && (paddr == `MBC_ADDR_INSTR);
  wire [3:0]  wsel = working_select_reg[3:0];

  // Module selector: modules 0..5 map to slots 0..5, system module 8 to its own slot
  function [3:0] mod_sel;
    input [3:0] nib;
    begin
      if (nib == `MBC_SPEC_SYS)
        mod_sel = {1'b1, `MBC_SLOT_SYS};
      else if (!nib[3] && (nib[2:0] <= `MBC_MOD_LAST))
        mod_sel = {1'b1, nib[2:0]};
      else
        mod_sel = 4'h0;
    end
  endfunction

  // Replace one bit of a word
  function [15:0] put_bit;
    input [15:0] val;
    input [3:0]  pos;
    input        b;
    reg   [15:0] m;
    begin
      m = 16'h0001 << pos;
      put_bit = b ? (val | m) : (val & ~m);
    end
  endfunction

  wire [3:0]  ms = mod_sel(spc[3:0]);
  wire [3:0]  md = mod_sel(ins[11:8]);
  wire [15:0] m_src = mod_reg[{ms[2:0], spc[6:4]}];
  wire [15:0] m_dst = mod_reg[{md[2:0], ins[14:12]}];
  wire        pfx_ext = pfx_valid_reg && (pfx_idx_reg == `MBC_PFX_EXT);

  // Source operand fetch, shared by transfers and bit to carry
  always @* begin
    acc_cur = acc_reg[wsel];
    src16 = 16'h0000;
    src8 = 1'b1;
    up8 = pfx_valid_reg ? pfx_reg[pfx_idx_reg] : 8'h00;
    if (!ins[15]) begin
      src16 = {8'h00, spc};
    end else if (spc[3:0] == `MBC_SPEC_ACCN) begin
      src16 = acc_reg[{1'b0, spc[6:4]}];
      src8 = 1'b0;
    end else if (spc == {1'b0, `MBC_SPEC_ACC}) begin
      src16 = acc_cur;
      src8 = 1'b0;
    end else if (ms[3] && (spc[3:0] == `MBC_SPEC_SYS)) begin
      if (spc[6:4] == `MBC_SYS_WSEL)
        src16 = {8'h00, working_select_reg};
      else if (spc[6:4] == `MBC_SYS_FLAGS)
        src16 = {8'h00, cpu_flag_reg};
      else
        src16 = m_src;
    end else if (ms[3]) begin
      src16 = m_src;
      src8 = 1'b0;
    end
    // 8-bit source to 16-bit target takes zero or the prefix byte on top
    full16 = src8 ? {up8, src16[7:0]} : src16;
  end

  // Instruction decode
  always @* begin
    c_we = 1'b0; c_val = 1'b0; sz_we = 1'b0; acc_we = 1'b0; mod_we = 1'b0;
    ap_we = 1'b0; psf_we = 1'b0; dp_we = 1'b0; pfx_we = 1'b0; bad = 1'b0;
    acc_idx = wsel; mod_idx = {md[2:0], ins[14:12]};
    acc_val = 16'h0000; mod_val = 16'h0000; dp_val = full16; dp_idx = dst[6];
    b8_val = 8'h00; pfx_val = src16[7:0]; pfx_idx = dst[6:4];
    bw16 = 16'h0000;
    if (ins == `MBC_OP_CLR_C) begin
      c_we = 1'b1;
    end else if (ins == `MBC_OP_SET_C) begin
      c_we = 1'b1;
      c_val = 1'b1;
    end else if (ins[11:8] == `MBC_NIB_ACCOP && ins[3:0] == `MBC_NIB_ACCOP) begin
      if (ins[15:12] == `MBC_HI_ACC_FROM_C) begin
        acc_we = 1'b1;
        sz_we = 1'b1;
        acc_val = put_bit(acc_cur, ins[7:4], cpu_flag_reg[`MBC_F_C]);
      end else if (ins[15:12] == `MBC_HI_C_FROM_ACC) begin
        c_we = 1'b1;
        c_val = acc_cur[ins[7:4]];
      end else begin
        bad = 1'b1;
      end
    end else if (ins[11:8] == `MBC_NIB_BIT) begin
      // Only module operands are legal here; others leave carry alone
      if (ins[15] && ms[3]) begin
        c_we = 1'b1;
        c_val = src16[{1'b0, ins[14:12]}];
      end else begin
        bad = 1'b1;
      end
    end else if (ins[15] && ins[3:0] == `MBC_NIB_BIT) begin
      // Bit clear (bit 7 low) or set; flags change only when the target is the flag register
      if (!md[3]) begin
        bad = 1'b1;
      end else if (ins[11:8] == `MBC_SPEC_SYS && ins[14:12] == `MBC_SYS_WSEL) begin
        ap_we = 1'b1;
        bw16 = put_bit({8'h00, working_select_reg}, {1'b0, ins[6:4]}, ins[7]);
        b8_val = bw16[7:0]; // Byte wide target, upper half of the helper is dropped on purpose
      end else if (ins[11:8] == `MBC_SPEC_SYS && ins[14:12] == `MBC_SYS_FLAGS) begin
        psf_we = 1'b1;
        bw16 = put_bit({8'h00, cpu_flag_reg}, {1'b0, ins[6:4]}, ins[7]);
        b8_val = bw16[7:0];
      end else begin
        mod_we = 1'b1;
        mod_val = put_bit(m_dst, {1'b0, ins[6:4]}, ins[7]);
      end
    end else if (pfx_ext) begin
      // Upper bank reached through the prefix
      if (dst[3:0] == `MBC_SPEC_ACCN) begin
        acc_we = 1'b1;
        acc_idx = {1'b1, dst[6:4]};
        acc_val = full16;
      end else begin
        bad = 1'b1;
      end
    end else if (dst[3:0] == `MBC_SPEC_ACCN) begin
      acc_we = 1'b1;
      acc_idx = {1'b0, dst[6:4]};
      acc_val = full16;
    end else if (dst == `MBC_SPEC_ACC) begin
      acc_we = 1'b1;
      acc_val = full16;
    end else if (dst[3:0] == `MBC_SPEC_PFX) begin
      pfx_we = 1'b1;
    end else if (dst[3:0] == `MBC_SPEC_DP && dst[5:4] == `MBC_SPEC_DP_SEL) begin
      dp_we = 1'b1;
    end else if (dst == `MBC_SPEC_NUL) begin
      bad = 1'b0;
    end else if (dst[3:0] == `MBC_SPEC_SYS) begin
      // System module registers are byte wide; only the low byte lands
      b8_val = src16[7:0];
      if (dst[6:4] == `MBC_SYS_WSEL)
        ap_we = 1'b1;
      else if (dst[6:4] == `MBC_SYS_FLAGS)
        psf_we = 1'b1;
      else begin
        mod_we = 1'b1;
        mod_val = {8'h00, src16[7:0]};
      end
    end else if (md[3]) begin
      mod_we = 1'b1;
      mod_val = full16;
    end else begin
      bad = 1'b1;
    end
  end

  // APB read mux; one word per register, unmapped answers with an error
  always @* begin
    rd_val = 32'h0000_0000;
    rd_err = 1'b0;
    if (paddr == `MBC_ADDR_INSTR)
      rd_val = {16'h0000, instr_reg};
    else if (paddr == `MBC_ADDR_FLAGS)
      rd_val = {24'h00_0000, cpu_flag_reg};
    else if (paddr == `MBC_ADDR_WSEL)
      rd_val = {24'h00_0000, working_select_reg};
    else if (paddr == `MBC_ADDR_STAT)
      rd_val = {19'h0_0000, bad_reg, pfx_valid_reg, pfx_idx_reg, pfx_reg[pfx_idx_reg]};
    else if (paddr == `MBC_ADDR_DP0)
      rd_val = {16'h0000, dp_reg[0]};
    else if (paddr == `MBC_ADDR_DP1)
      rd_val = {16'h0000, dp_reg[1]};
    else if (paddr >= `MBC_ADDR_ACC && paddr <= `MBC_ADDR_ACC_E && paddr[1:0] == 2'b00)
      rd_val = {16'h0000, acc_reg[paddr[5:2]]};
    else if (paddr >= `MBC_ADDR_MOD && paddr <= `MBC_ADDR_MOD_E && paddr[1:0] == 2'b00)
      rd_val = {16'h0000, mod_reg[paddr[7:2]]};
    else
      rd_err = 1'b1;
  end

  // APB handshake: one wait state, so the answer is registered on the same edge that raises pready
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      prdata <= pwrite ? 32'h0000_0000 : rd_val;
      pslverr <= rd_err;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // State update; an executed instruction and a direct write never coincide
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (i = 0; i < ACC_NUM; i = i + 1)
        acc_reg[i] <= 16'h0000;
      for (i = 0; i < MOD_WORDS; i = i + 1)
        mod_reg[i] <= 16'h0000;
      for (i = 0; i < 8; i = i + 1)
        pfx_reg[i] <= 8'h00;
      dp_reg[0] <= 16'h0000;
      dp_reg[1] <= 16'h0000;
      working_select_reg <= 8'h00;
      cpu_flag_reg <= 8'h00;
      instr_reg <= 16'h0000;
      pfx_valid_reg <= 1'b0;
      pfx_idx_reg <= 3'h0;
      bad_reg <= 1'b0;
    end else if (exec) begin
      instr_reg <= ins;
      bad_reg <= bad;
      // Any instruction other than a prefix load retires the prefix
      pfx_valid_reg <= pfx_we;
      if (pfx_we) begin
        pfx_idx_reg <= pfx_idx;
        pfx_reg[pfx_idx] <= pfx_val;
      end
      if (acc_we)
        acc_reg[acc_idx] <= acc_val;
      if (mod_we)
        mod_reg[mod_idx] <= mod_val;
      if (dp_we)
        dp_reg[dp_idx] <= dp_val;
      if (ap_we)
        working_select_reg <= b8_val;
      if (psf_we)
        cpu_flag_reg <= b8_val;
      else begin
        if (c_we)
          cpu_flag_reg[`MBC_F_C] <= c_val;
        if (sz_we) begin
          cpu_flag_reg[`MBC_F_S] <= acc_val[15];
          cpu_flag_reg[`MBC_F_Z] <= (acc_val == 16'h0000);
        end
      end
    end else if (wr_acc && !pslverr) begin
      if (paddr == `MBC_ADDR_FLAGS)
        cpu_flag_reg <= pwdata[7:0];
      else if (paddr == `MBC_ADDR_WSEL)
        working_select_reg <= pwdata[7:0];
      else if (paddr == `MBC_ADDR_DP0)
        dp_reg[0] <= pwdata[15:0];
      else if (paddr == `MBC_ADDR_DP1)
        dp_reg[1] <= pwdata[15:0];
      else if (paddr >= `MBC_ADDR_ACC && paddr <= `MBC_ADDR_ACC_E)
        acc_reg[paddr[5:2]] <= pwdata[15:0];
      else if (paddr >= `MBC_ADDR_MOD && paddr <= `MBC_ADDR_MOD_E)
        mod_reg[paddr[7:2]] <= pwdata[15:0];
    end
  end

endmodule

// [tb/mbc_exec_assertions.sv]
// Port-level protocol checker for the bit and carry execution unit
`timescale 1ns/1ps
`include "mbc_consts.vh"
module mbc_chk #(
  parameter ACC_NUM   = 16,
  parameter MOD_WORDS = 64
) (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Access phase still waiting for its answer
  sequence s_wait;
    psel && penable && !pready;
  endsequence
  // Read answer being handed back
  sequence s_rd;
    pready && psel && !pwrite;
  endsequence
  // Exactly one wait state, so a slip in the latency shows at once
  property p_one_wait;
    s_wait |=> pready && !$past(pready);
  endproperty
  property p_pulse;
    pready |=> !pready;
  endproperty
  property p_cause;
    $rose(pready) |-> $past(psel && penable);
  endproperty
  property p_err_rdy;
    pslverr |-> pready;
  endproperty
  property p_err_zero;
    s_rd and (pslverr == 1'b1) |-> prdata == 32'h0000_0000;
  endproperty
  property p_acc_width;
    s_rd and (paddr >= `MBC_ADDR_ACC && paddr <= `MBC_ADDR_ACC_E) |-> prdata[31:16] == 16'h0000;
  endproperty
  property p_flag_width;
    s_rd and (paddr == `MBC_ADDR_FLAGS) |-> prdata[31:8] == 24'h00_0000 && !pslverr;
  endproperty
  property p_wsel_width;
    s_rd and (paddr == `MBC_ADDR_WSEL) |-> prdata[31:8] == 24'h00_0000 && !pslverr;
  endproperty
  a_one_wait:   assert property (p_one_wait)   else $error("pready not one cycle after access");
  a_pulse:      assert property (p_pulse)      else $error("pready longer than one cycle");
  a_cause:      assert property (p_cause)      else $error("pready without access phase");
  a_err_rdy:    assert property (p_err_rdy)    else $error("pslverr without pready");
  a_err_zero:   assert property (p_err_zero)   else $error("refused read data not zero");
  a_acc_width:  assert property (p_acc_width)  else $error("accumulator wider than 16 bits");
  a_flag_width: assert property (p_flag_width) else $error("flag read malformed");
  a_wsel_width: assert property (p_wsel_width) else $error("select read malformed");
endmodule
bind mbc_exec mbc_chk #(.ACC_NUM(ACC_NUM), .MOD_WORDS(MOD_WORDS)) u_chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

// [tb/tb_move_bit_carry_exec.sv]
// Self-checking bench for the bit and carry execution unit
`timescale 1ns/1ps
`include "mbc_consts.vh"
module tb_move_bit_carry_exec;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  wire  [31:0] prdata;
  wire         pready, pslverr;
  logic        last_err;
  int          err_total = 0, compares = 0;
  mbc_exec u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  // 40 MHz clock
  initial begin
    forever #12.5 pclk = ~pclk;
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
      if (n > 20) begin err_total++; stop_test(); end
    end while (pready !== 1'b1);
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask
  task automatic ex(input logic [15:0] op);
    wr(`MBC_ADDR_INSTR, {16'h0000, op});
  endtask
  task automatic rc(input string nm, input logic [11:0] a, input logic [31:0] e);
    logic [31:0] q;
    apb(1'b0, a, 32'h0000_0000, q);
    chk(nm, e, q);
  endtask
  function automatic logic [11:0] acc(input int n);
    return `MBC_ADDR_ACC + 12'(4 * n);
  endfunction
  // Reset values and a refused address
  task automatic t_reset();
    rc("flags", `MBC_ADDR_FLAGS, 32'h0000_0000);
    rc("acc0", acc(0), 32'h0000_0000);
    rc("unmapped", 12'h800, 32'h0000_0000);
    chk("pslverr", 32'h0000_0001, {31'h0, last_err});
    $display("test reset done");
  endtask
  // Carry set and clear leave S, Z and E alone
  task automatic t_carry();
    wr(`MBC_ADDR_FLAGS, 32'h0000_000e);
    ex(`MBC_OP_SET_C);
    rc("flags", `MBC_ADDR_FLAGS, 32'h0000_000f);
    ex(`MBC_OP_CLR_C);
    rc("flags", `MBC_ADDR_FLAGS, 32'h0000_000e);
    $display("test carry done");
  endtask
  // Accumulator bit moves at the top bit position and at bit 0, with S and Z updates
  task automatic t_acc_bit();
    wr(`MBC_ADDR_WSEL, 32'h0000_0003);
    wr(acc(3), 32'h0000_8000);
    wr(`MBC_ADDR_FLAGS, 32'h0000_0002);
    ex(16'hfafa);
    rc("acc3", acc(3), 32'h0000_0000);
    rc("flags", `MBC_ADDR_FLAGS, 32'h0000_0004);
    wr(`MBC_ADDR_FLAGS, 32'h0000_0001);
    ex(16'hfafa);
    rc("acc3", acc(3), 32'h0000_8000);
    rc("flags", `MBC_ADDR_FLAGS, 32'h0000_0003);
    wr(`MBC_ADDR_FLAGS, 32'h0000_000c);
    ex(16'heafa);
    rc("flags", `MBC_ADDR_FLAGS, 32'h0000_000d);
    ex(16'hea0a);
    rc("flags", `MBC_ADDR_FLAGS, 32'h0000_000c);
    $display("test acc bit done");
  endtask
  // Register bit to carry, bit clear, and a module outside the allowed set
  task automatic t_reg_bit();
    wr(`MBC_ADDR_MOD, 32'h0000_00fe);
    wr(`MBC_ADDR_FLAGS, 32'h0000_0001);
    ex(16'h8700);
    rc("flags", `MBC_ADDR_FLAGS, 32'h0000_0000);
    ex(16'h9700);
    rc("flags", `MBC_ADDR_FLAGS, 32'h0000_0001);
    ex(16'h8706);
    rc("flags", `MBC_ADDR_FLAGS, 32'h0000_0001);
    rc("stat", `MBC_ADDR_STAT, 32'h0000_1000);
    wr(`MBC_ADDR_MOD + 12'h028, 32'h0000_00ff);
    ex(16'ha177);
    rc("mod1", `MBC_ADDR_MOD + 12'h028, 32'h0000_007f);
    rc("flags", `MBC_ADDR_FLAGS, 32'h0000_0001);
    ex(16'hc807);
    rc("flags", `MBC_ADDR_FLAGS, 32'h0000_0000);
    $display("test reg bit done");
  endtask
  // Width rules, prefix high byte for one instruction, upper bank
  task automatic t_xfer();
    wr(acc(1), 32'h0000_ffff);
    ex(16'h1955);
    rc("acc1", acc(1), 32'h0000_0055);
    ex(16'h0b12);
    ex(16'h1934);
    rc("acc1", acc(1), 32'h0000_1234);
    ex(16'h1956);
    rc("acc1", acc(1), 32'h0000_0056);
    ex(16'h0b01);
    ex(16'h3f10);
    rc("dp0", `MBC_ADDR_DP0, 32'h0000_0110);
    wr(acc(1), 32'h0000_beef);
    ex(16'ha919);
    rc("acc2", acc(2), 32'h0000_beef);
    ex(16'h2b30);
    ex(16'h0940);
    rc("acc8", acc(8), 32'h0000_3040);
    rc("acc0", acc(0), 32'h0000_0000);
    $display("test transfer done");
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_carry();
    t_acc_bit();
    t_reg_bit();
    t_xfer();
    stop_test();
  end
endmodule
